// ### inc/mtc_pkg.sv
// Package for the motor controller timer, event and register block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package mtc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TIMER_COUNT_HIGH = 8'h00;
  localparam logic [7:0] OFF_TIMER_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFF_CAPTURE_PREVIOUS = 8'h08;
  localparam logic [7:0] OFF_CAPTURE_CURRENT = 8'h0c;
  localparam logic [7:0] OFF_NEXT_COMMUTATION = 8'h10;
  localparam logic [7:0] OFF_DEMAG_VALUE = 8'h14;
  localparam logic [7:0] OFF_MULTIPLIER_WEIGHT = 8'h18;
  localparam logic [7:0] OFF_PRESCALE_SAMPLING = 8'h1c;
  localparam logic [7:0] OFF_INTERRUPT_ENABLE = 8'h20;
  localparam logic [7:0] OFF_INTERRUPT_FLAGS = 8'h24;
  localparam logic [7:0] OFF_CONTROL = 8'h28;
  localparam logic [7:0] OFF_PWM_PRELOAD = 8'h2c;
  // ----------------------------------------------------------------
  // Interrupt bit positions (mask and flags share the layout except the ratio bits)
  // ----------------------------------------------------------------
  localparam int BIT_PWM_UPDATE = 7;
  localparam int BIT_SPEED_ERROR = 6;
  localparam int BIT_RATIO_UP = 6;
  localparam int BIT_RATIO_UPDATE = 5;
  localparam int BIT_RATIO_DOWN = 5;
  localparam int BIT_CURRENT_LIMIT = 4;
  localparam int BIT_ESTOP = 3;
  localparam int BIT_ZERO_CROSS = 2;
  localparam int BIT_DEMAG_END = 1;
  localparam int BIT_COMMUTATION = 0;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_CLOCK_ENABLE = 0;
  localparam int CTL_AUTOSWITCH = 1;
  localparam int CTL_SPEED_SENSOR = 2;
  localparam int CTL_CURRENT_VOLTAGE = 3;
  localparam int CTL_COMPARE_SOURCE = 4;
  localparam int CTL_HW_DEMAG = 5;
  localparam int CTL_SIM_DEMAG = 6;
  localparam int CTL_SW_CAPTURE = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [11:0] PWM_COUNT_ZERO = 12'h000;
  localparam logic [31:0] APB_READ_ZERO = 32'h00000000;
endpackage

// ### hw/mtc_timer_regs.sv
// Motor controller commutation timer, capture/compare and interrupt events.
// Assumes a synchronous APB master and synchronous event inputs on pclk.
//
// Summary of operation
// - Clock enable low holds the PWM counter at zero.
// - Setting clock enable starts counter and forces the PWM preload active.
// - That forced transfer also raises the PWM update event.
// - In wait the block runs on and enabled interrupts wake the CPU.
// - In halt the timer and events stop, bus access still works, and the block never wakes the CPU.
// - Events map to three vectors, gated by enable and global mask.
// - One ratio enable gates both ratio up and ratio down flags.
// - Enable mask bits: PWM update bit 7 down to commutation bit 0.
// - Current-limit event only counts in voltage mode.
// - Demag-end interrupt needs its mask and hardware or simulated demag.
// - Timer high reads the 8-bit counter; software read may capture it.
// - In speed mode timer low extends the timer to 16 bits.
// - Previous capture holds prior capture, or captured timer low byte.
// - Current capture read in speed mode blocks captures until previous read.
// - Next-commutation compare holds the timer value for next commutation.
// - Demag register is compare for simulated, capture for hardware demag.
// - In speed mode demag register against timer raises speed error.
// - Autoswitched zero-crossing loads compare with capture times weight / 256.
// - Prescaler upper nibble sets current mode sampling rate.
// - Prescaler lower nibble prescales timer; ratio events step it.
// - Autoswitched flags are set by hardware, cleared only by software.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module mtc_timer_regs
  import mtc_pkg::*;
(
  input wire logic pclk, // APB clock, 250 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic cpu_global_mask, // CPU global interrupt mask, high masks
  input wire logic cpu_halt, // CPU in halt mode
  input wire logic pwm_period_end, // PWM counter period event
  input wire logic zero_cross_event, // Back-EMF zero-crossing detected
  input wire logic demag_end_event, // Hardware demag end detected
  input wire logic commutation_event, // Commutation or capture event
  input wire logic estop_event, // Emergency stop event
  input wire logic current_limit_event, // Current feedback reached limit
  input wire logic speed_capture_event, // Sensor edge for speed capture
  input wire logic ratio_up_event, // Timer overflow needing slower ratio
  input wire logic ratio_down_event, // Timer too fast needing faster ratio
  output logic [11:0] pwm_count, // Three-phase PWM counter
  output logic [7:0] pwm_active, // Active copy of PWM config
  output logic [7:0] commutation_prescale, // Step ratio nibble, zero extended
  output logic [3:0] current_mode_pick_rate, // Sampling ratio for current mode
  output logic commutation_match, // Timer reached next commutation compare
  output logic irq_vector_events, // Vector for ratio, speed, estop, current
  output logic irq_vector_commutation, // Vector for zero-cross, demag, commutation
  output logic irq_vector_pwm // Vector for PWM update
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] timer_count_high;
    logic [7:0] timer_count_low;
    logic [7:0] capture_previous;
    logic [7:0] capture_current;
    logic [7:0] next_commutation_compare;
    logic [7:0] demagnetization_value;
    logic [7:0] multiplier_weight;
    logic [7:0] prescale_and_sampling;
    logic [7:0] interrupt_enable_mask;
    logic [7:0] interrupt_flags;
    logic [7:0] control;
    logic [7:0] pwm_preload;
    logic [7:0] pwm_config;
    logic [3:0] prescale_count;
    logic [11:0] pwm_counter;
    logic capture_blocked;
    logic clock_enable_seen;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic match;
    logic irq_events;
    logic irq_commutation;
    logic irq_pwm;
  } state_t;

  state_t state;
  state_t next_state;

  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic running;
  logic speed_mode;
  logic [15:0] product;
  logic [7:0] pending;
  logic [7:0] gated;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Answer in the first access cycle; the ready flop is set in setup, so it adds no wait
  assign setup = psel && !penable;
  assign mapped = (paddr <= OFF_PWM_PRELOAD) && (paddr[1:0] == 2'b00);
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_acc = psel && penable && !pwrite && mapped;
  // Halt stops the counters and events; bus accesses still land
  assign running = state.control[CTL_CLOCK_ENABLE] && !cpu_halt;
  assign speed_mode = state.control[CTL_SPEED_SENSOR];
  // Zero-crossing compare reload source
  assign product = (state.control[CTL_COMPARE_SOURCE] ? state.capture_previous
                    : state.capture_current) * state.multiplier_weight;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.ready = 1'b0;
    next_state.slverr = 1'b0;
    next_state.match = 1'b0;
    // Bus answer prepared in setup, valid during access
    if (setup) begin
      next_state.ready = 1'b1;
      next_state.slverr = !mapped;
      case (paddr)
        OFF_TIMER_COUNT_HIGH: next_state.rdata = {24'h000000, state.timer_count_high};
        OFF_TIMER_COUNT_LOW: next_state.rdata = {24'h000000, state.timer_count_low};
        OFF_CAPTURE_PREVIOUS: next_state.rdata = {24'h000000, state.capture_previous};
        OFF_CAPTURE_CURRENT: next_state.rdata = {24'h000000, state.capture_current};
        OFF_NEXT_COMMUTATION: next_state.rdata = {24'h000000, state.next_commutation_compare};
        OFF_DEMAG_VALUE: next_state.rdata = {24'h000000, state.demagnetization_value};
        OFF_MULTIPLIER_WEIGHT: next_state.rdata = {24'h000000, state.multiplier_weight};
        OFF_PRESCALE_SAMPLING: next_state.rdata = {24'h000000, state.prescale_and_sampling};
        OFF_INTERRUPT_ENABLE: next_state.rdata = {24'h000000, state.interrupt_enable_mask};
        OFF_INTERRUPT_FLAGS: next_state.rdata = {24'h000000, state.interrupt_flags};
        OFF_CONTROL: next_state.rdata = {24'h000000, state.control};
        OFF_PWM_PRELOAD: next_state.rdata = {24'h000000, state.pwm_preload};
        default: next_state.rdata = APB_READ_ZERO;
      endcase
    end else if (psel && penable) begin
      next_state.ready = 1'b0;
    end
    // Software writes land even with clock disabled
    if (wr_acc) begin
      case (paddr)
        OFF_TIMER_COUNT_HIGH: next_state.timer_count_high = pwdata[7:0];
        OFF_TIMER_COUNT_LOW: next_state.timer_count_low = pwdata[7:0];
        OFF_CAPTURE_PREVIOUS: next_state.capture_previous = pwdata[7:0];
        OFF_CAPTURE_CURRENT: next_state.capture_current = pwdata[7:0];
        OFF_NEXT_COMMUTATION: next_state.next_commutation_compare = pwdata[7:0];
        OFF_DEMAG_VALUE: next_state.demagnetization_value = pwdata[7:0];
        OFF_MULTIPLIER_WEIGHT: next_state.multiplier_weight = pwdata[7:0];
        OFF_PRESCALE_SAMPLING: next_state.prescale_and_sampling = pwdata[7:0];
        OFF_INTERRUPT_ENABLE: next_state.interrupt_enable_mask = pwdata[7:0];
        // Write zero clears; writing one has no effect
        OFF_INTERRUPT_FLAGS: next_state.interrupt_flags =
          state.interrupt_flags & pwdata[7:0];
        OFF_CONTROL: next_state.control = pwdata[7:0];
        OFF_PWM_PRELOAD: next_state.pwm_preload = pwdata[7:0];
        default: next_state.control = next_state.control;
      endcase
    end
    // Software capture on timer read; current-capture read blocks
    if (rd_acc && speed_mode) begin
      if (paddr == OFF_TIMER_COUNT_HIGH && state.control[CTL_SW_CAPTURE]
          && !state.capture_blocked) begin
        next_state.capture_current = state.timer_count_high;
        next_state.capture_previous = state.timer_count_low;
      end
      if (paddr == OFF_CAPTURE_CURRENT)
        next_state.capture_blocked = 1'b1;
      if (paddr == OFF_CAPTURE_PREVIOUS)
        next_state.capture_blocked = 1'b0;
    end
    // PWM counter held at zero while the clock is off
    next_state.clock_enable_seen = state.control[CTL_CLOCK_ENABLE];
    if (!state.control[CTL_CLOCK_ENABLE]) begin
      next_state.pwm_counter = PWM_COUNT_ZERO;
    end else if (running) begin
      next_state.pwm_counter = 12'(state.pwm_counter + 12'h001);
    end
    // Enable edge forces preload transfer and a PWM update event
    if (state.control[CTL_CLOCK_ENABLE] && !state.clock_enable_seen) begin
      next_state.pwm_config = state.pwm_preload;
      next_state.interrupt_flags[BIT_PWM_UPDATE] = 1'b1;
    end
    if (running) begin
      if (pwm_period_end) begin
        next_state.pwm_config = state.pwm_preload;
        next_state.interrupt_flags[BIT_PWM_UPDATE] = 1'b1;
      end
      // Timer prescaled by the step ratio; 16 bits in speed mode
      if (state.prescale_count >= state.prescale_and_sampling[3:0]) begin
        next_state.prescale_count = 4'h0;
        if (speed_mode)
          {next_state.timer_count_high, next_state.timer_count_low} =
            16'({state.timer_count_high, state.timer_count_low} + 16'h0001);
        else
          next_state.timer_count_high = 8'(state.timer_count_high + 8'h01);
      end else begin
        next_state.prescale_count = 4'(state.prescale_count + 4'h1);
      end
      next_state.match = (state.timer_count_high == state.next_commutation_compare);
      // Speed error from demag register compare
      if (speed_mode && state.timer_count_high == state.demagnetization_value)
        next_state.interrupt_flags[BIT_SPEED_ERROR] = 1'b1;
      // Ratio events step the prescaler and set their own flags
      if (ratio_up_event) begin
        next_state.prescale_and_sampling[3:0] =
          4'(state.prescale_and_sampling[3:0] + 4'h1);
        next_state.interrupt_flags[BIT_RATIO_UP] = 1'b1;
      end else if (ratio_down_event) begin
        next_state.prescale_and_sampling[3:0] =
          4'(state.prescale_and_sampling[3:0] - 4'h1);
        next_state.interrupt_flags[BIT_RATIO_DOWN] = 1'b1;
      end
      if (speed_capture_event && speed_mode && !state.capture_blocked) begin
        next_state.capture_current = state.timer_count_high;
        next_state.capture_previous = state.timer_count_low;
      end
      if (zero_cross_event && !speed_mode) begin
        next_state.capture_previous = state.capture_current;
        next_state.capture_current = state.timer_count_high;
        next_state.interrupt_flags[BIT_ZERO_CROSS] = 1'b1;
        if (state.control[CTL_AUTOSWITCH])
          next_state.next_commutation_compare = product[15:8];
      end
      // Hardware demag captures the timer; simulated compares against it
      if (!speed_mode && state.control[CTL_HW_DEMAG] && demag_end_event) begin
        next_state.demagnetization_value = state.timer_count_high;
        next_state.interrupt_flags[BIT_DEMAG_END] = 1'b1;
      end
      if (!speed_mode && state.control[CTL_SIM_DEMAG]
          && state.timer_count_high == state.demagnetization_value)
        next_state.interrupt_flags[BIT_DEMAG_END] = 1'b1;
      if (commutation_event)
        next_state.interrupt_flags[BIT_COMMUTATION] = 1'b1;
      if (estop_event)
        next_state.interrupt_flags[BIT_ESTOP] = 1'b1;
      if (current_limit_event && !state.control[CTL_CURRENT_VOLTAGE])
        next_state.interrupt_flags[BIT_CURRENT_LIMIT] = 1'b1;
    end
    // Interrupt requests: enable and global mask, none in halt
    next_state.irq_pwm = gated[BIT_PWM_UPDATE] && !cpu_global_mask && !cpu_halt;
    next_state.irq_events = (|gated[6:3]) && !cpu_global_mask && !cpu_halt;
    next_state.irq_commutation = (|gated[2:0]) && !cpu_global_mask && !cpu_halt;
  end

  // Flag gating; bit 6 and 5 share the ratio enable, speed error uses bit 6 mask
  always_comb begin
    pending = state.interrupt_flags;
    gated = 8'h00;
    gated[BIT_PWM_UPDATE] = pending[BIT_PWM_UPDATE] && state.interrupt_enable_mask[7];
    gated[6] = (pending[BIT_RATIO_UP] || pending[BIT_RATIO_DOWN])
               && state.interrupt_enable_mask[BIT_RATIO_UPDATE];
    gated[5] = speed_mode && pending[BIT_SPEED_ERROR]
               && state.interrupt_enable_mask[BIT_SPEED_ERROR];
    gated[4] = pending[BIT_CURRENT_LIMIT] && state.interrupt_enable_mask[4]
               && !state.control[CTL_CURRENT_VOLTAGE];
    gated[3] = pending[BIT_ESTOP] && state.interrupt_enable_mask[3];
    gated[2] = pending[BIT_ZERO_CROSS] && state.interrupt_enable_mask[2];
    gated[1] = pending[BIT_DEMAG_END] && state.interrupt_enable_mask[1]
               && (state.control[CTL_HW_DEMAG] || state.control[CTL_SIM_DEMAG]);
    gated[0] = pending[BIT_COMMUTATION] && state.interrupt_enable_mask[0];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.slverr;
  assign pwm_count = state.pwm_counter;
  assign pwm_active = state.pwm_config;
  assign commutation_prescale = {4'h0, state.prescale_and_sampling[3:0]};
  assign current_mode_pick_rate = state.prescale_and_sampling[7:4];
  assign commutation_match = state.match;
  assign irq_vector_events = state.irq_events;
  assign irq_vector_commutation = state.irq_commutation;
  assign irq_vector_pwm = state.irq_pwm;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_counter_zero;
    @(posedge pclk) disable iff (!presetn)
      !state.control[CTL_CLOCK_ENABLE] |=> pwm_count == PWM_COUNT_ZERO;
  endproperty
  a_counter_zero: assert property (p_counter_zero) else $error("pwm counter not held");

  sequence s_enable_rise;
    state.control[CTL_CLOCK_ENABLE] && !state.clock_enable_seen;
  endsequence
  property p_enable_load;
    @(posedge pclk) disable iff (!presetn)
      s_enable_rise |=> pwm_active == $past(state.pwm_preload);
  endproperty
  a_enable_load: assert property (p_enable_load) else $error("no forced preload");

  property p_enable_flag;
    @(posedge pclk) disable iff (!presetn)
      s_enable_rise |=> state.interrupt_flags[BIT_PWM_UPDATE];
  endproperty
  a_enable_flag: assert property (p_enable_flag) else $error("no pwm update flag");

  property p_halt_quiet;
    @(posedge pclk) disable iff (!presetn)
      cpu_halt |=> !irq_vector_pwm && !irq_vector_events && !irq_vector_commutation;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("irq in halt");

  property p_global_mask;
    @(posedge pclk) disable iff (!presetn)
      cpu_global_mask |=> !irq_vector_pwm;
  endproperty
  a_global_mask: assert property (p_global_mask) else $error("irq while masked");

  property p_flag_no_set;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFF_INTERRUPT_FLAGS && !running
        |=> (state.interrupt_flags & ~$past(state.interrupt_flags)) == 8'h00;
  endproperty
  a_flag_no_set: assert property (p_flag_no_set) else $error("software set a flag");

  property p_current_mode;
    @(posedge pclk) disable iff (!presetn)
      state.control[CTL_CURRENT_VOLTAGE] && !state.interrupt_flags[BIT_CURRENT_LIMIT]
        && !wr_acc |=> !state.interrupt_flags[BIT_CURRENT_LIMIT];
  endproperty
  a_current_mode: assert property (p_current_mode) else $error("current limit in current mode");

  property p_zero_cross_load;
    @(posedge pclk) disable iff (!presetn)
      running && zero_cross_event && !speed_mode && state.control[CTL_AUTOSWITCH] && !wr_acc
        |=> state.next_commutation_compare == $past(product[15:8]);
  endproperty
  a_zero_cross_load: assert property (p_zero_cross_load) else $error("compare reload wrong");

  // A bus write to the prescaler in the same cycle loses its low nibble to the step
  property p_ratio_step;
    @(posedge pclk) disable iff (!presetn)
      running && ratio_up_event && !wr_acc
        |=> commutation_prescale[3:0] == 4'($past(state.prescale_and_sampling[3:0]) + 4'h1);
  endproperty
  a_ratio_step: assert property (p_ratio_step) else $error("ratio step missed");

  property p_ratio_flag;
    @(posedge pclk) disable iff (!presetn)
      running && ratio_down_event && !ratio_up_event
        |=> state.interrupt_flags[BIT_RATIO_DOWN];
  endproperty
  a_ratio_flag: assert property (p_ratio_flag) else $error("no ratio flag");

  // Blocked capture pair only moves by a direct software write
  sequence s_capture_held;
    speed_mode && state.capture_blocked && !wr_acc;
  endsequence
  property p_capture_held;
    @(posedge pclk) disable iff (!presetn)
      s_capture_held |=> $stable(state.capture_current);
  endproperty
  a_capture_held: assert property (p_capture_held) else $error("capture while blocked");
endmodule

// ### bench/rotor_sense_model.sv
// Far-side model: rotor position, back-EMF and current sensing events.
// Assumes the bench requests events on fire, one cycle at a time, on pclk.
`timescale 1ns/10ps
module rotor_sense_model (
  input wire logic pclk, // Bench clock
  input wire logic presetn, // Reset, active low
  input wire logic [8:0] fire, // Event requests from the bench
  output logic [8:0] evt // One-cycle event pulses to the block
);
  // Registered pulses keep events off the bench's own drive edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= 9'h000;
    end else begin
      evt <= fire;
    end
  end
endmodule

// ### bench/test_motor_ctrl_timer_irq_regs.sv
// Self-checking bench for the timer, event and register block.
// Assumes the package offsets and the zero-wait APB slave of the design.
`timescale 1ns/10ps
module test_motor_ctrl_timer_irq_regs;
  import mtc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_global_mask, cpu_halt;
  logic [7:0] paddr, pwm_active, commutation_prescale, r;
  logic [31:0] pwdata, prdata;
  logic [8:0] fire, evt;
  logic [11:0] pwm_count;
  logic [3:0] current_mode_pick_rate;
  logic commutation_match, irq_vector_events, irq_vector_commutation, irq_vector_pwm;
  logic [31:0] m [0:11];
  int error_cnt, num_checks, seed, n;
  mtc_timer_regs i_mtc_timer_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_global_mask(cpu_global_mask),
    .cpu_halt(cpu_halt), .pwm_period_end(evt[8]), .zero_cross_event(evt[0]),
    .demag_end_event(evt[1]), .commutation_event(evt[2]), .estop_event(evt[3]),
    .current_limit_event(evt[4]), .speed_capture_event(evt[5]), .ratio_up_event(evt[6]),
    .ratio_down_event(evt[7]), .pwm_count(pwm_count), .pwm_active(pwm_active),
    .commutation_prescale(commutation_prescale),
    .current_mode_pick_rate(current_mode_pick_rate), .commutation_match(commutation_match),
    .irq_vector_events(irq_vector_events), .irq_vector_commutation(irq_vector_commutation),
    .irq_vector_pwm(irq_vector_pwm));
  rotor_sense_model i_rotor_sense_model (.pclk(pclk), .presetn(presetn), .fire(fire),
    .evt(evt));
  // Free-running 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; bounded wait, an idle cycle after release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test;
    end
    if (!w) chk("prdata", prdata, (a < 8'h30) ? m[a[5:2]] : APB_READ_ZERO);
    chk("pslverr", {31'h0, pslverr}, {31'h0, a >= 8'h30});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Flag writes clear with zero and keep with one
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    if (a == OFF_INTERRUPT_FLAGS) m[9] = m[9] & {24'h0, d};
    else if (a < 8'h30) m[a[5:2]] = {24'h0, d};
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task ev(input int b);
    fire <= 9'(1 << b);
    @(posedge pclk);
    fire <= 9'h000;
    repeat (3) @(posedge pclk);
  endtask
  task tend(input string nm);
    $display("test %s done", nm);
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, cpu_global_mask, cpu_halt} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 9'h000;
    error_cnt = 0;
    num_checks = 0;
    seed = 15;
    for (int i = 0; i < 12; i++) m[i] = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("pwm_count", {20'h0, pwm_count}, 32'h0);
    for (int i = 0; i < 13; i++) rd(8'(i * 4));
    tend("reset");
    r = 8'($random(seed));
    wr(OFF_MULTIPLIER_WEIGHT, r);
    wr(OFF_DEMAG_VALUE, ~r);
    wr(OFF_PRESCALE_SAMPLING, {r[7:4], 4'h3});
    wr(OFF_INTERRUPT_ENABLE, 8'ha0);
    wr(OFF_PWM_PRELOAD, r ^ 8'h5a);
    for (int i = 5; i < 12; i++) rd(8'(i * 4));
    chk("pick_rate", {28'h0, current_mode_pick_rate}, {28'h0, r[7:4]});
    chk("prescale", {24'h0, commutation_prescale}, 32'h3);
    tend("registers");
    wr(OFF_CONTROL, 8'h03);
    // Forced transfer shows one edge after the enable lands
    @(posedge pclk);
    m[9] = 32'h80;
    chk("pwm_active", {24'h0, pwm_active}, {24'h0, r ^ 8'h5a});
    chk("pwm_run", {31'h0, pwm_count != 12'h0}, 32'h1);
    rd(OFF_INTERRUPT_FLAGS);
    chk("irq_pwm", {31'h0, irq_vector_pwm}, 32'h1);
    cpu_global_mask <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("irq_pwm_masked", {31'h0, irq_vector_pwm}, 32'h0);
    cpu_global_mask <= 1'b0;
    wr(OFF_INTERRUPT_FLAGS, 8'h7f);
    rd(OFF_INTERRUPT_FLAGS);
    ev(8);
    m[9] = m[9] | 32'h80;
    tend("startup");
    ev(6);
    m[9] = m[9] | 32'h40;
    chk("prescale_up", {24'h0, commutation_prescale}, 32'h4);
    chk("irq_events", {31'h0, irq_vector_events}, 32'h1);
    ev(7);
    m[9] = m[9] | 32'h20;
    chk("prescale_down", {24'h0, commutation_prescale}, 32'h3);
    rd(OFF_INTERRUPT_FLAGS);
    ev(4);
    m[9] = m[9] | 32'h10;
    rd(OFF_INTERRUPT_FLAGS);
    wr(OFF_INTERRUPT_FLAGS, 8'h00);
    wr(OFF_CONTROL, 8'h0b);
    ev(4);
    rd(OFF_INTERRUPT_FLAGS);
    tend("events");
    // An estop fired during halt sets no flag; the same estop after halt sets it
    cpu_halt <= 1'b1;
    ev(3);
    cpu_halt <= 1'b0;
    rd(OFF_INTERRUPT_FLAGS);
    ev(3);
    m[9] = m[9] | 32'h08;
    rd(OFF_INTERRUPT_FLAGS);
    tend("power");
    // Autoswitched zero crossing: compare from current capture times weight
    r = 8'($random(seed));
    wr(OFF_INTERRUPT_ENABLE, 8'ha4);
    wr(OFF_CAPTURE_CURRENT, r);
    ev(0);
    m[2] = m[3];
    m[4] = (m[3] * m[6]) >> 8;
    m[9] = m[9] | 32'h04;
    chk("irq_comm", {31'h0, irq_vector_commutation}, 32'h1);
    rd(OFF_CAPTURE_PREVIOUS);
    rd(OFF_NEXT_COMMUTATION);
    rd(OFF_INTERRUPT_FLAGS);
    // Timer wraps within about 1024 cycles at step ratio 3
    n = 0;
    while (commutation_match !== 1'b1 && n < 1100) begin
      @(posedge pclk);
      n++;
    end
    chk("match", {31'h0, commutation_match}, 32'h1);
    tend("autoswitch");
    // Speed mode: reading current capture blocks the next capture
    wr(OFF_CONTROL, 8'h05);
    wr(OFF_CAPTURE_CURRENT, ~r);
    rd(OFF_CAPTURE_CURRENT);
    ev(5);
    rd(OFF_CAPTURE_CURRENT);
    tend("capture");
    finish_test;
  end
endmodule
